/* File: rtl/btsd_decode.sv */
`include "btsd_params.svh"
module btsd_decode (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    instr_valid,
  input  wire btsd_pkg::btsd_word_type instr_word,
  output btsd_pkg::btsd_rd_type        file_rd,
  input  wire logic [7:0]              file_data,
  output logic                         discard,
  output logic                         skip_taken,
  output logic                         exec_valid,
  output btsd_pkg::btsd_word_type      exec_word,
  output logic                         status_we
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  btsd_pkg::btsd_state_type state;
  btsd_pkg::btsd_state_type next_state;
  logic [3:0] op;
  logic       is_clr;
  logic       is_set;
  logic [2:0] bit_sel;
  logic       bit_val;
  logic       do_skip;
  logic       live;

  assign op      = instr_word[`BTSD_OP_MSB:`BTSD_OP_LSB];
  assign is_clr  = op == `BTSD_OP_TEST_CLR;
  assign is_set  = op == `BTSD_OP_TEST_SET;
  assign bit_sel = instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB];
  // file data is read in the same cycle the address is presented
  assign bit_val = file_data[bit_sel];
  assign live    = instr_valid && state == btsd_pkg::BTSD_RUN;
  assign do_skip = live && ((is_clr && !bit_val)
                           || (is_set && bit_val));

  always_comb begin
    file_rd.valid = live && (is_clr || is_set);
    file_rd.addr  = instr_word[`BTSD_ADDR_MSB:`BTSD_ADDR_LSB];
  end

  // ----------------------------------------------------------------
  // skip sequencing
  // ----------------------------------------------------------------
  logic                     next_skip_taken;
  logic                     next_exec_valid;
  btsd_pkg::btsd_word_type  next_exec_word;

  always_comb begin
    next_state      = state;
    next_skip_taken = 1'b0;
    next_exec_valid = 1'b0;
    next_exec_word  = exec_word;
    case (state)
      btsd_pkg::BTSD_RUN: begin
        next_exec_valid = instr_valid;
        if (instr_valid) begin
          next_exec_word = instr_word;
        end
        if (do_skip) begin
          next_state      = btsd_pkg::BTSD_FLUSH;
          next_skip_taken = 1'b1;
        end
      end
      btsd_pkg::BTSD_FLUSH: begin
        // the no-op stands in for the dropped word only, so a fetch stall
        // issues nothing and the skip still costs a single extra cycle
        next_exec_valid = instr_valid;
        next_exec_word  = `BTSD_NOP_WORD;
        if (instr_valid) begin
          next_state = btsd_pkg::BTSD_RUN;
        end
      end
      default: next_state = btsd_pkg::BTSD_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      state      <= btsd_pkg::BTSD_RUN;
      skip_taken <= 1'b0;
      exec_valid <= 1'b0;
      exec_word  <= `BTSD_NOP_WORD;
    end else begin
      state      <= next_state;
      skip_taken <= next_skip_taken;
      exec_valid <= next_exec_valid;
      exec_word  <= next_exec_word;
    end
  end

  // the fetched word is dropped while flushing
  assign discard   = state == btsd_pkg::BTSD_FLUSH && instr_valid;
  // bit tests never write status flags
  assign status_we = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a taken skip followed by its flush cycle
  sequence skip_seq;
    do_skip ##1 skip_taken;
  endsequence

  // the flush cycle in which the prefetched word arrives
  sequence skip_fetch_seq;
    skip_seq ##0 instr_valid;
  endsequence

  // the flush cycle held open by a fetch stall
  sequence skip_stall_seq;
    skip_seq ##0 !instr_valid;
  endsequence

  property skip_nop_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    skip_fetch_seq |=> exec_valid && exec_word == `BTSD_NOP_WORD;
  endproperty
  skip_then_nop_a: assert property (skip_nop_p)
    else $error("no nop after skip");

  property clear_skip_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live && is_clr && !file_data[instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB]]
    |=> skip_taken;
  endproperty
  clear_skip_a: assert property (clear_skip_p)
    else $error("clear test did not skip");

  property set_skip_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live && is_set && file_data[instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB]]
    |=> skip_taken;
  endproperty
  set_skip_a: assert property (set_skip_p)
    else $error("set test did not skip");

  property set_noskip_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live && is_set && !file_data[instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB]]
    |=> !skip_taken;
  endproperty
  set_noskip_a: assert property (set_noskip_p)
    else $error("set test skipped on zero");

  property no_skip_one_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    instr_valid && !do_skip |=> state == btsd_pkg::BTSD_RUN;
  endproperty
  no_skip_one_a: assert property (no_skip_one_p)
    else $error("extra cycle without skip");

  property flush_discard_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    skip_fetch_seq |-> discard;
  endproperty
  flush_discard_a: assert property (flush_discard_p)
    else $error("prefetched word kept");

  property status_quiet_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    (is_clr || is_set) |-> !status_we;
  endproperty
  status_quiet_a: assert property (status_quiet_p)
    else $error("status written");

  property addr_field_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    file_rd.valid
    |-> file_rd.addr == instr_word[`BTSD_ADDR_MSB:`BTSD_ADDR_LSB];
  endproperty
  addr_field_a: assert property (addr_field_p)
    else $error("bad file address");

  property skip_two_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    do_skip ##1 instr_valid |=> state == btsd_pkg::BTSD_RUN;
  endproperty
  skip_two_a: assert property (skip_two_p)
    else $error("skip longer than two cycles");

  property stall_quiet_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    skip_stall_seq |=> !exec_valid;
  endproperty
  stall_no_exec_a: assert property (stall_quiet_p)
    else $error("extra no-op during fetch stall");

  property one_discard_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    skip_fetch_seq |=> !discard;
  endproperty
  single_discard_a: assert property (one_discard_p)
    else $error("second word dropped after skip");

  property word_pass_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live |=> exec_valid && exec_word == $past(instr_word);
  endproperty
  word_executes_a: assert property (word_pass_p)
    else $error("accepted word not executed next cycle");

  property clear_noskip_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live && is_clr && file_data[instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB]]
    |=> !skip_taken;
  endproperty
  clear_noskip_a: assert property (clear_noskip_p)
    else $error("clear test skipped on one");

  property plain_noskip_p;
    @(posedge clk_sys) disable iff (!rst_sync)
    live && op != `BTSD_OP_TEST_CLR && op != `BTSD_OP_TEST_SET
    |=> !skip_taken;
  endproperty
  other_noskip_a: assert property (plain_noskip_p)
    else $error("skip on a word that is no bit test");
endmodule

/* File: inc/btsd_params.svh */
`ifndef BTSD_PARAMS_SVH
`define BTSD_PARAMS_SVH
// Summary of operation
// - Both bit tests take a file address 0..127 and a bit index 0..7.
// - Word 01 10bb bfff ffff skips the next word when the bit is 0.
// - Word 01 11bb bfff ffff tests a bit and skips when set, same fields.
// - The set form skips when the bit reads 1; neither form alters status.
// - A taken skip discards the prefetched word and runs a no-op instead.
// - One word; one cycle when not skipping, two cycles when skipping.

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define BTSD_OP_MSB      13
`define BTSD_OP_LSB      10
`define BTSD_OP_TEST_CLR 4'h6
`define BTSD_OP_TEST_SET 4'h7
`define BTSD_BIT_MSB     9
`define BTSD_BIT_LSB     7
`define BTSD_ADDR_MSB    6
`define BTSD_ADDR_LSB    0
`define BTSD_NOP_WORD    14'h0000
`endif

/* File: inc/btsd_pkg.sv */
package btsd_pkg;
  typedef logic [13:0] btsd_word_type;
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } btsd_rd_type;
  typedef enum logic {BTSD_RUN, BTSD_FLUSH} btsd_state_type;
endpackage

/* File: dv/btsd_file_model.sv */
module btsd_file_model (
  input  wire btsd_pkg::btsd_rd_type file_rd,
  output logic [7:0]                 file_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // data register file, combinational read
  // ----------------------------------------------------------------
  logic [7:0] mem [128];
  // unselected read shows inverted data so a stray sample cannot match
  always_comb begin
    file_data = file_rd.valid ? mem[file_rd.addr] : ~mem[file_rd.addr];
  end
endmodule

/* File: dv/btsd_decode_tb_top.sv */
module btsd_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk_sys = 0;
  logic                    rst_n = 0;
  logic                    instr_valid = 0;
  btsd_pkg::btsd_word_type instr_word = '0;
  btsd_pkg::btsd_word_type exec_word;
  btsd_pkg::btsd_word_type exp_word;
  btsd_pkg::btsd_rd_type   file_rd;
  logic [7:0]              file_data;
  logic                    discard, skip_taken, exec_valid, status_we;
  logic                    exp_valid = 0, exp_skip = 0, flush = 0;
  int                      fails = 0, comparisons = 0;
  logic [31:0]             r;
  always #50 clk_sys = ~clk_sys;
  btsd_decode i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .file_rd(file_rd),
    .file_data(file_data), .discard(discard), .skip_taken(skip_taken),
    .exec_valid(exec_valid), .exec_word(exec_word), .status_we(status_we));
  btsd_file_model i_file (.file_rd(file_rd), .file_data(file_data));
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic calc_skip(logic [13:0] w, logic [7:0] d);
    return (w[13:10] == 4'h6 && !d[w[9:7]])
      || (w[13:10] == 4'h7 && d[w[9:7]]);
  endfunction
  // one fetch slot: check last edge's results, then present a word
  task automatic step(input logic v, input logic [13:0] w);
    @(negedge clk_sys);
    if (exp_valid) check(exec_word, exp_word);
    check(exec_valid, exp_valid);
    check(skip_taken, exp_skip);
    check(status_we, 1'b0);
    instr_valid = v;
    instr_word = w;
    #1;
    check(discard, v && flush);
    if (v && !flush && w[13:11] == 3'h3)
      check(file_rd, {1'b1, w[6:0]});
    else
      check(file_rd.valid, 1'b0);
    exp_valid = v;
    exp_skip = 1'b0;
    if (v && flush) begin
      exp_word = '0;
      flush = 1'b0;
    end else if (v) begin
      exp_word = w;
      exp_skip = calc_skip(w, i_file.mem[w[6:0]]);
      flush = exp_skip;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(84));
    foreach (i_file.mem[i]) i_file.mem[i] = $urandom;
    i_file.mem[127] = 8'h80;
    i_file.mem[0] = 8'hfe;
    repeat (4) @(negedge clk_sys);
    rst_n = 1;
    repeat (3) step(1'b0, '0);
    // boundary operands, back-to-back skips, stall inside a flush
    step(1'b1, {4'h6, 3'h0, 7'h00});
    step(1'b1, {4'h7, 3'h7, 7'h7f});
    step(1'b1, {4'h7, 3'h7, 7'h7f});
    step(1'b1, {4'h6, 3'h7, 7'h7f});
    step(1'b1, {4'h6, 3'h0, 7'h00});
    step(1'b0, '0);
    step(1'b1, 14'h3fff);
    step(1'b1, {4'h7, 3'h0, 7'h00});
    step(1'b1, {4'h6, 3'h7, 7'h7f});
    repeat (3000) begin
      r = $urandom;
      if (r[15]) r[13:11] = 3'h3;
      step(r[20:18] != 3'h0, r[13:0]);
    end
    step(1'b0, '0);
    // reset in a flush cycle: registers clear and the pending no-op is lost
    step(1'b1, 14'h0000);
    step(1'b1, {4'h6, 3'h0, 7'h00});
    step(1'b1, 14'h3fff);
    rst_n = 0;
    instr_valid = 0;
    {exp_valid, exp_skip, flush} = 3'h0;
    #1;
    check(skip_taken, 1'b0);
    check(exec_valid, 1'b0);
    check(exec_word, 14'h0000);
    repeat (2) step(1'b0, '0);
    rst_n = 1;
    repeat (3) step(1'b0, '0);
    step(1'b1, {4'h7, 3'h7, 7'h7f});
    step(1'b1, 14'h0000);
    step(1'b0, '0);
    give_verdict();
  end
endmodule
